// ==== verilog/apc_pkg.sv ====
// Constants, field layouts and carrier types for the converter power and
// configuration control block.
// Assumes a 16-bit command word, most significant bit first per frame.
package apc_pkg;

   localparam int        WORD_W        = 16;
   localparam int        BITCNT_W      = 5;
   localparam logic [4:0] LAST_BIT     = 5'h0F;

   // Word routing.
   localparam int        SEL_BIT       = 15;
   localparam int        CODE_HI       = 15;
   localparam int        CODE_LO       = 11;
   localparam logic [4:0] CFG_CODE     = 5'h10;

   // Configuration register fields.
   localparam int        REFERENCE_SELECT_BIT    = 10;
   localparam int        AVERAGE_ENABLE_BIT     = 9;
   localparam int        AVERAGE_COUNT_HI       = 8;
   localparam int        AVERAGE_COUNT_LO       = 7;
   localparam int        SPM_HI        = 4;
   localparam int        SPM_LO        = 3;

   // Mode control register fields.
   localparam int        SCAN_HI       = 14;
   localparam int        SCAN_LO       = 11;
   localparam int        PM_HI         = 4;
   localparam int        PM_LO         = 3;
   localparam int        SOFTWARE_CONVERT_BIT_BIT     = 1;
   localparam int        INTCLK_BIT    = 0;
   localparam logic [3:0] SCAN_NULL_MIN = 4'hA;

   // Field codes.
   localparam logic [1:0] PM_NORMAL    = 2'h0;
   localparam logic [1:0] PM_SHDN      = 2'h1;
   localparam logic [1:0] PM_STBY      = 2'h2;
   localparam logic [1:0] SPM_NORMAL   = 2'h0;
   localparam logic [1:0] SPM_FULL     = 2'h1;
   localparam logic [1:0] SPM_PART     = 2'h2;

   // Conversions per result.
   localparam logic [5:0] AVG_ONE      = 6'h01;
   localparam logic [5:0] AVG_4        = 6'h04;
   localparam logic [5:0] AVG_8        = 6'h08;
   localparam logic [5:0] AVG_16       = 6'h10;
   localparam logic [5:0] AVG_32       = 6'h20;

   // Conversions discarded after a wake-up.
   localparam logic [1:0] WAKE_DISCARD = 2'h2;

   typedef struct packed {
      logic       reference_select;
      logic       average_enable;
      logic [1:0] average_count;
      logic [1:0] static_power_field;
   } apc_cfg_s;

   typedef struct packed {
      logic [3:0] scan;
      logic [1:0] pm;
      logic       int_clk;
   } apc_mode_s;

   localparam apc_cfg_s  CFG_RST  = '{1'b0, 1'b0, 2'h0, 2'h0};
   localparam apc_mode_s MODE_RST = '{4'h0, 2'h0, 1'b0};

   typedef enum logic [1:0] {
      PS_RUN   = 2'b00,
      PS_ARMED = 2'b01,
      PS_DOWN  = 2'b10
   } apc_pwr_e;

endpackage

// ==== verilog/apc_sync2.sv ====
// Two-flop synchroniser for a group of levels.
// Assumes a synchronous active-high reset and a clock enable that freezes it.
`timescale 1ns/1ps
module apc_sync2 #(
   parameter int         WIDTH   = 1,
   parameter logic [7:0] RST_VAL = 8'h00
) (
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_q;

   // The first stage feeds only the second stage.
   always_ff @(posedge clk) begin
      if (srst) begin
         meta_q <= RST_VAL[WIDTH-1:0];
         q      <= RST_VAL[WIDTH-1:0];
      end else if (ce) begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule

// ==== verilog/apc_top.sv ====
// Command decode and power management of a multichannel SAR converter.
// Assumes a serial host on SCLK, CS_N and DIN, and converter logic on
// REF_CLK that pulses CONV_DONE and SEQ_DONE.
`timescale 1ns/1ps
module apc_top (
   input  wire logic       REF_CLK,
   input  wire logic       SRST,
   input  wire logic       CE,
   input  wire logic       SCLK,
   input  wire logic       CS_N,
   input  wire logic       DIN,
   input  wire logic       CONVERT_START_N,
   input  wire logic       CONV_DONE,
   input  wire logic       SEQ_DONE,
   output logic            PWR_MAIN,
   output logic            PWR_BIAS,
   output logic            REF_DIFF,
   output logic            INT_CLK,
   output logic [3:0]      SCAN_MODE,
   output logic [5:0]      AVG_PER_RESULT,
   output logic            RESULT_OK,
   output logic            START_REQ
);

   ////////////////////////////////////////////////////////////////////////
   // Link side: shift in one word per frame on the serial clock.

   logic [apc_pkg::BITCNT_W-1:0] bit_cnt_q;
   logic [apc_pkg::WORD_W-1:0]   shift_q;
   logic [apc_pkg::WORD_W-1:0]   word_q;
   logic                         tog_q;

   // The count restarts with every frame, since the serial clock may stop.
   always_ff @(posedge SCLK or posedge CS_N) begin
      if (CS_N) begin
         bit_cnt_q <= '0;
      end else if (bit_cnt_q <= apc_pkg::LAST_BIT) begin
         bit_cnt_q <= bit_cnt_q + 5'h01;
      end
   end

   always_ff @(posedge SCLK or posedge SRST) begin
      if (SRST) begin
         shift_q <= '0;
      end else if (!CS_N) begin
         shift_q <= {shift_q[apc_pkg::WORD_W-2:0], DIN};
      end
   end

   // The word stays put until the next frame's sixteenth bit, which leaves
   // the core side ample time to take it after the toggle is seen.
   always_ff @(posedge SCLK or posedge SRST) begin
      if (SRST) begin
         word_q <= '0;
         tog_q  <= 1'b0;
      end else if (!CS_N && bit_cnt_q == apc_pkg::LAST_BIT) begin
         word_q <= {shift_q[apc_pkg::WORD_W-2:0], DIN};
         tog_q  <= ~tog_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Crossing into the core clock domain.

   logic [2:0] sync_q;
   logic       cs_s;
   logic       cnv_s;
   logic       tog_s;
   logic       cs_prev_q;
   logic       cnv_prev_q;
   logic       tog_prev_q;

   apc_sync2 #(
      .WIDTH   (3),
      .RST_VAL (8'h06)
   ) u_sync (
      .clk  (REF_CLK),
      .srst (SRST),
      .ce   (CE),
      .d    ({CS_N, CONVERT_START_N, tog_q}),
      .q    (sync_q)
   );

   assign cs_s  = sync_q[2];
   assign cnv_s = sync_q[1];
   assign tog_s = sync_q[0];

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         cs_prev_q  <= 1'b1;
         cnv_prev_q <= 1'b1;
         tog_prev_q <= 1'b0;
      end else if (CE) begin
         cs_prev_q  <= cs_s;
         cnv_prev_q <= cnv_s;
         tog_prev_q <= tog_s;
      end
   end

   logic cs_fall;
   logic cs_rise;
   logic cnv_fall;
   logic word_evt;

   assign cs_fall  = cs_prev_q & ~cs_s;
   assign cs_rise  = ~cs_prev_q & cs_s;
   assign cnv_fall = cnv_prev_q & ~cnv_s;
   assign word_evt = tog_s ^ tog_prev_q;

   ////////////////////////////////////////////////////////////////////////
   // Command decode and registers.

   logic                 mode_wr;
   logic                 cfg_wr;
   apc_pkg::apc_cfg_s    cfg_q;
   apc_pkg::apc_mode_s   mode_q;
   logic                 software_convert_bit_q;

   // Null scan codes leave the previous mode in force.
   assign mode_wr = word_evt && !word_q[apc_pkg::SEL_BIT]
                    && word_q[apc_pkg::SCAN_HI:apc_pkg::SCAN_LO]
                       < apc_pkg::SCAN_NULL_MIN;
   assign cfg_wr  = word_evt && word_q[apc_pkg::SEL_BIT]
                    && word_q[apc_pkg::CODE_HI:apc_pkg::CODE_LO]
                       == apc_pkg::CFG_CODE;

   // Power states never touch these, so settings survive a wake-up.
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         cfg_q <= apc_pkg::CFG_RST;
      end else if (CE && cfg_wr) begin
         cfg_q.reference_select <= word_q[apc_pkg::REFERENCE_SELECT_BIT];
         cfg_q.average_enable  <= word_q[apc_pkg::AVERAGE_ENABLE_BIT];
         cfg_q.average_count   <= word_q[apc_pkg::AVERAGE_COUNT_HI:apc_pkg::AVERAGE_COUNT_LO];
         cfg_q.static_power_field    <= word_q[apc_pkg::SPM_HI:apc_pkg::SPM_LO];
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         mode_q <= apc_pkg::MODE_RST;
      end else if (CE && mode_wr) begin
         mode_q.scan    <= word_q[apc_pkg::SCAN_HI:apc_pkg::SCAN_LO];
         mode_q.pm      <= word_q[apc_pkg::PM_HI:apc_pkg::PM_LO];
         mode_q.int_clk <= word_q[apc_pkg::INTCLK_BIT];
      end
   end

   // A soft start waits for the end of the frame that carried it.
   logic soft_go;

   assign soft_go = cs_rise && software_convert_bit_q && mode_q.int_clk;

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         software_convert_bit_q <= 1'b0;
      end else if (CE) begin
         if (mode_wr && word_q[apc_pkg::SOFTWARE_CONVERT_BIT_BIT]) begin
            software_convert_bit_q <= 1'b1;
         end else if (soft_go) begin
            software_convert_bit_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Power state machine.

   function automatic logic auto_sel(input logic [1:0] pm);
      auto_sel = (pm == apc_pkg::PM_SHDN) || (pm == apc_pkg::PM_STBY);
   endfunction

   function automatic logic [5:0] avg_count(input apc_pkg::apc_cfg_s c,
                                            input logic int_clk);
      if (!c.average_enable || !int_clk) begin
         avg_count = apc_pkg::AVG_ONE;
      end else begin
         unique case (c.average_count)
            2'h0: avg_count = apc_pkg::AVG_4;
            2'h1: avg_count = apc_pkg::AVG_8;
            2'h2: avg_count = apc_pkg::AVG_16;
            2'h3: avg_count = apc_pkg::AVG_32;
         endcase
      end
   endfunction

   apc_pkg::apc_pwr_e state_q;
   apc_pkg::apc_pwr_e state_d;
   logic              auto_on;
   logic              wake_int;

   assign auto_on  = auto_sel(mode_q.pm);
   assign wake_int = cnv_fall || soft_go;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         apc_pkg::PS_RUN: begin
            if (auto_on && mode_q.int_clk && SEQ_DONE) begin
               state_d = apc_pkg::PS_DOWN;
            end else if (auto_on && !mode_q.int_clk && cs_fall) begin
               state_d = apc_pkg::PS_ARMED;
            end
         end
         apc_pkg::PS_ARMED: begin
            if (!auto_on || mode_q.int_clk) begin
               state_d = apc_pkg::PS_RUN;
            end else if (cs_rise) begin
               state_d = apc_pkg::PS_DOWN;
            end
         end
         apc_pkg::PS_DOWN: begin
            if (!auto_on) begin
               state_d = apc_pkg::PS_RUN;
            end else if (mode_q.int_clk && wake_int) begin
               state_d = apc_pkg::PS_RUN;
            end else if (!mode_q.int_clk && cs_fall) begin
               state_d = apc_pkg::PS_ARMED;
            end
         end
         default: state_d = apc_pkg::PS_RUN;
      endcase
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         state_q <= apc_pkg::PS_RUN;
      end else if (CE) begin
         state_q <= state_d;
      end
   end

   // Results after a wake-up are held invalid for two conversions.
   logic [1:0] disc_q;
   logic [1:0] disc_d;

   always_comb begin
      disc_d = disc_q;
      if (state_q == apc_pkg::PS_DOWN && state_d != apc_pkg::PS_DOWN) begin
         disc_d = apc_pkg::WAKE_DISCARD;
      end else if (CONV_DONE && disc_q != 2'h0) begin
         disc_d = disc_q - 2'h1;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         disc_q <= 2'h0;
      end else if (CE) begin
         disc_q <= disc_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered outputs.

   logic main_d;
   logic bias_d;

   // Static shutdown wins over any auto power state.
   always_comb begin
      main_d = 1'b1;
      bias_d = 1'b1;
      if (cfg_q.static_power_field == apc_pkg::SPM_FULL) begin
         main_d = 1'b0;
         bias_d = 1'b0;
      end else if (cfg_q.static_power_field == apc_pkg::SPM_PART) begin
         main_d = 1'b0;
      end else if (state_d == apc_pkg::PS_DOWN) begin
         main_d = 1'b0;
         bias_d = mode_q.pm != apc_pkg::PM_SHDN;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         PWR_MAIN       <= 1'b1;
         PWR_BIAS       <= 1'b1;
         REF_DIFF       <= 1'b0;
         INT_CLK        <= 1'b0;
         SCAN_MODE      <= 4'h0;
         AVG_PER_RESULT <= apc_pkg::AVG_ONE;
         RESULT_OK      <= 1'b1;
         START_REQ      <= 1'b0;
      end else if (CE) begin
         PWR_MAIN       <= main_d;
         PWR_BIAS       <= bias_d;
         REF_DIFF       <= cfg_q.reference_select;
         INT_CLK        <= mode_q.int_clk;
         SCAN_MODE      <= mode_q.scan;
         AVG_PER_RESULT <= avg_count(cfg_q, mode_q.int_clk);
         RESULT_OK      <= disc_d == 2'h0;
         START_REQ      <= mode_q.int_clk && wake_int;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (SRST || !CE);

   property p_mode_wr;
      mode_wr |=> mode_q.pm == $past(word_q[apc_pkg::PM_HI:apc_pkg::PM_LO]);
   endproperty
   a_mode_wr: assert property (p_mode_wr)
      else $error("mode write lost");

   property p_sel_high;
      (word_evt && word_q[apc_pkg::SEL_BIT]) |=> $stable(mode_q);
   endproperty
   a_sel_high: assert property (p_sel_high)
      else $error("data word changed mode");

   property p_cfg_wr;
      cfg_wr |=> cfg_q.static_power_field == $past(word_q[apc_pkg::SPM_HI:apc_pkg::SPM_LO])
                 && cfg_q.reference_select == $past(word_q[apc_pkg::REFERENCE_SELECT_BIT]);
   endproperty
   a_cfg_wr: assert property (p_cfg_wr)
      else $error("configuration write lost");

   property p_full_off;
      cfg_q.static_power_field == apc_pkg::SPM_FULL |=> !PWR_MAIN && !PWR_BIAS;
   endproperty
   a_full_off: assert property (p_full_off)
      else $error("full shutdown not applied");

   property p_part_off;
      cfg_q.static_power_field == apc_pkg::SPM_PART |=> !PWR_MAIN && PWR_BIAS;
   endproperty
   a_part_off: assert property (p_part_off)
      else $error("partial shutdown wrong");

   property p_ext_down;
      (state_q == apc_pkg::PS_ARMED && cs_rise && auto_on
       && !mode_q.int_clk) |=> state_q == apc_pkg::PS_DOWN ##1 !PWR_MAIN;
   endproperty
   a_ext_down: assert property (p_ext_down)
      else $error("no shutdown at frame end");

   property p_ext_wake;
      (state_q == apc_pkg::PS_DOWN && cs_fall && auto_on
       && !mode_q.int_clk) |=> state_q == apc_pkg::PS_ARMED;
   endproperty
   a_ext_wake: assert property (p_ext_wake)
      else $error("no wake at frame start");

   property p_int_down;
      (state_q == apc_pkg::PS_RUN && auto_on && mode_q.int_clk && SEQ_DONE)
         |=> state_q == apc_pkg::PS_DOWN;
   endproperty
   a_int_down: assert property (p_int_down)
      else $error("no shutdown after sequence");

   property p_int_wake;
      (state_q == apc_pkg::PS_DOWN && auto_on && mode_q.int_clk && cnv_fall)
         |=> state_q == apc_pkg::PS_RUN && START_REQ;
   endproperty
   a_int_wake: assert property (p_int_wake)
      else $error("no wake on convert start");

   property p_discard;
      (state_q == apc_pkg::PS_DOWN ##1 state_q != apc_pkg::PS_DOWN)
         |-> disc_q == apc_pkg::WAKE_DISCARD && !RESULT_OK;
   endproperty
   a_discard: assert property (p_discard)
      else $error("results not held after wake");

   property p_retain;
      (state_q == apc_pkg::PS_DOWN && !cfg_wr) |=> $stable(cfg_q);
   endproperty
   a_retain: assert property (p_retain)
      else $error("configuration lost in shutdown");

   property p_avg32;
      (cfg_q.average_enable && mode_q.int_clk && cfg_q.average_count == 2'h3)
         |=> AVG_PER_RESULT == apc_pkg::AVG_32;
   endproperty
   a_avg32: assert property (p_avg32)
      else $error("averaging count wrong");

   c_ext_cycle: cover property (state_q == apc_pkg::PS_DOWN
                                ##[1:400] state_q == apc_pkg::PS_ARMED);
   c_soft_wake: cover property (state_q == apc_pkg::PS_DOWN && soft_go);
   c_avg_on:    cover property (AVG_PER_RESULT == apc_pkg::AVG_16);

endmodule

// ==== dv/apc_host.sv ====
// Serial host model: frame select, link clock and data pins.
// Assumes the bench calls its tasks one at a time from one process.
`timescale 1ns/1ps
module apc_host (
   output logic SCLK,
   output logic CS_N,
   output logic DIN
);
   ////////////////////////////////////////////////////////////////////////
   initial begin
      SCLK = 1'b0;
      CS_N = 1'b1;
      DIN  = 1'b0;
   end
   // The link clock stands still outside frames.
   task automatic frame_open();
      CS_N = 1'b0;
      #100;
   endtask
   // Bits go out MSB first, one per link clock rise.
   task automatic shift(input logic [15:0] w, input int n);
      for (int i = 15; i > 15 - n; i--) begin
         DIN = w[i];
         #62.5 SCLK = 1'b1;
         #62.5 SCLK = 1'b0;
      end
   endtask
   // The long hold lets a soft convert land before the frame ends.
   task automatic frame_close();
      #400 CS_N = 1'b1;
      DIN = ~DIN;
      #400;
   endtask
endmodule

// ==== dv/apc_top_tb.sv ====
// Self-checking bench for the power and configuration control block.
// Assumes the host model in apc_host and a 20 MHz core clock.
`timescale 1ns/1ps
module apc_top_tb;
   logic        ref_clk = 1'b0;
   logic        srst = 1'b1;
   logic        conv_n = 1'b1;
   logic        conv_done = 1'b0;
   logic        seq_done = 1'b0;
   logic        sclk, cs_n, din;
   logic        pwr_main, pwr_bias, ref_diff, int_clk, result_ok, start_req;
   logic [3:0]  scan_mode;
   logic [5:0]  avg_per_result;
   int          failures = 0;
   int          comparisons = 0;
   int          starts = 0;
   int e_ref = 0, e_avg = 0, e_average_count = 0, e_spm = 0, e_pm = 0, e_int = 0;
   int e_scan = 0, e_down = 0, e_ok = 1;
   logic [31:0] rs = 32'hA6D6A54D;
   logic        ce = 1'b1;
   logic [15:0] cw;
   logic [15:0] wq[$];
   ////////////////////////////////////////////////////////////////////////
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (start_req === 1'b1) starts++;
   apc_host host (.SCLK(sclk), .CS_N(cs_n), .DIN(din));
   apc_top uut (
      .REF_CLK(ref_clk), .SRST(srst), .CE(ce), .SCLK(sclk), .CS_N(cs_n),
      .DIN(din), .CONVERT_START_N(conv_n), .CONV_DONE(conv_done),
      .SEQ_DONE(seq_done), .PWR_MAIN(pwr_main), .PWR_BIAS(pwr_bias),
      .REF_DIFF(ref_diff), .INT_CLK(int_clk), .SCAN_MODE(scan_mode),
      .AVG_PER_RESULT(avg_per_result), .RESULT_OK(result_ok),
      .START_REQ(start_req)
   );
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("Comparisons %0d, failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Reference model of the two registers.
   task automatic model_wr(input logic [15:0] w);
      if (w[15:11] == 5'h10) begin
         e_ref = w[10];
         e_avg = w[9];
         e_average_count = w[8:7];
         e_spm = w[4:3];
      end else if (!w[15] && w[14:11] < 4'hA) begin
         e_scan = w[14:11];
         e_pm = w[4:3];
         e_int = w[0];
      end
   endtask
   task automatic chk_cfg();
      int ea;
      ea = (e_avg && e_int) ? 4 << e_average_count : 1;
      check(8'(ref_diff), 8'(e_ref));
      check(8'(avg_per_result), 8'(ea));
      check(8'(int_clk), 8'(e_int));
      check(8'(scan_mode), 8'(e_scan));
   endtask
   task automatic chk_pwr();
      int em;
      int eb;
      em = (e_spm == 1 || e_spm == 2) ? 0 : !e_down;
      eb = e_spm == 1 ? 0 : e_spm == 2 ? 1 : !(e_down && e_pm == 1);
      check(8'(pwr_main), 8'(em));
      check(8'(pwr_bias), 8'(eb));
   endtask
   // Words enter the model only once a whole frame has gone out.
   task automatic wr(input logic [15:0] w, input int n);
      if (n == 16) wq.push_back(w);
      host.frame_open();
      host.shift(w, n);
      host.frame_close();
      repeat (8) @(posedge ref_clk);
      if (n == 16) model_wr(wq.pop_front());
   endtask
   // Select 0 pulses a finished conversion, any other a finished sequence.
   task automatic pulse(input int sel);
      @(posedge ref_clk);
      if (sel == 0) conv_done <= 1'b1;
      else seq_done <= 1'b1;
      @(posedge ref_clk);
      conv_done <= 1'b0;
      seq_done <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask
   // Two conversions after a wake must pass before results count.
   task automatic conv2();
      pulse(0);
      check(8'(result_ok), 8'(e_ok));
      pulse(0);
      e_ok = 1;
      check(8'(result_ok), 8'(e_ok));
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #1000000;
      failures++;
      finish_test();
   end
   initial begin
      repeat (10) @(posedge ref_clk);
      srst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk_cfg();
      chk_pwr();
      check(8'(result_ok), 8'h01);
      for (int i = 0; i < 10; i++) begin
         rs = xs(rs);
         wr({5'h10, rs[10:5], 2'h0, rs[2:0]}, 16);
         wr({1'b0, 1'b0, rs[13:11], 10'h000, rs[16]}, 16);
         chk_cfg();
         chk_pwr();
      end
      $display("random configuration test done");
      wr({5'h13, 11'h7FF}, 16);
      wr({1'b0, 4'hA, 10'h000, ~int_clk}, 16);
      wr({5'h10, 11'h7FF}, 8);
      chk_cfg();
      $display("ignored word test done");
      // While the enable is low the word must wait on the core side.
      cw = {5'h10, 1'(e_ref == 0), 10'h000};
      ce <= 1'b0;
      host.frame_open();
      host.shift(cw, 16);
      host.frame_close();
      repeat (8) @(posedge ref_clk);
      chk_cfg();
      ce <= 1'b1;
      repeat (8) @(posedge ref_clk);
      model_wr(cw);
      chk_cfg();
      $display("clock enable test done");
      for (int s = 0; s < 4; s++) begin
         wr({5'h10, 1'b1, 5'h00, 2'(s), 3'h0}, 16);
         chk_pwr();
         chk_cfg();
      end
      wr({5'h10, 11'h000}, 16);
      conv2();
      $display("static power test done");
      wr(16'h0001, 16);
      for (int a = 0; a < 4; a++) begin
         wr({5'h10, 1'b0, 1'b1, 2'(a), 7'h00}, 16);
         chk_cfg();
      end
      $display("averaging test done");
      wr(16'h0009, 16);
      pulse(1);
      e_down = 1;
      chk_pwr();
      @(posedge ref_clk) conv_n <= 1'b0;
      repeat (8) @(posedge ref_clk);
      conv_n <= 1'b1;
      e_down = 0;
      e_ok = 0;
      chk_pwr();
      check(8'(starts), 8'h01);
      conv2();
      pulse(1);
      e_down = 1;
      chk_pwr();
      wr(16'h000B, 16);
      e_down = 0;
      e_ok = 0;
      chk_pwr();
      check(8'(starts), 8'h02);
      conv2();
      $display("internal clock power test done");
      for (int p = 1; p < 3; p++) begin
         wr({1'b0, 4'h0, 6'h00, 2'(p), 3'h0}, 16);
         wr({5'h10, 11'h000}, 16);
         e_down = 1;
         chk_pwr();
         host.frame_open();
         repeat (8) @(posedge ref_clk);
         e_down = 0;
         e_ok = 0;
         chk_pwr();
         check(8'(result_ok), 8'h00);
         conv2();
         host.shift({5'h10, 11'h000}, 16);
         host.frame_close();
         repeat (8) @(posedge ref_clk);
         e_down = 1;
         chk_pwr();
         chk_cfg();
         wr(16'h0000, 16);
         e_down = 0;
         e_ok = 0;
         chk_pwr();
         conv2();
      end
      check(8'(starts), 8'h02);
      $display("external clock power test done");
      finish_test();
   end
endmodule
